/* hw/ppi_top.sv */
// Purpose: pipe tx compliance disparity, rx status, fast recovery, idle inference
// Assumes: status and ordered-set flags come from logic on ref_clk; sig_det is a pin
// Notes: control reached over apb
// Operation
// - force input encodes that word negative disparity
// - status codes ok, skp add, delete, detected
// - error codes decode, overflow, underflow, disparity
// - report highest priority status condition
// - multiple errors give decode error code
// - fast recovery drives cdr lock controls itself
// - user lock controls hidden in fast recovery
// - fts lock within 16 ns to 4 us
// - inference drives idle flag when inferred
// - sel 100: no fc/skp in 128 us
// - sel 101: no ts1/ts2 in 1280 UI
// - sel 110: no idle exit in 2000 UI
// - sel 111: no idle exit in 128 us
// - eieos not used as idle exit
// - sel 0xx: idle from eios detection
// - disabled: idle is inverted signal detect
// - rx detect done pulse with 011/000
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ppi_defines.svh"
module ppi_top
  import ppi_pkg::*;
#(
  parameter int WIN_CYC = `PPI_WIN_CYC,
  parameter int TS_CYC = `PPI_TS_CYC,
  parameter int EXIT_CYC = `PPI_EXIT_CYC,
  parameter int FTS_MIN_CYC = `PPI_FTS_MIN_CYC,
  parameter int FTS_MAX_CYC = `PPI_FTS_MAX_CYC
)(
  input wire logic ref_clk, // parallel clock
  input wire logic rst, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [15:0] tx_data_in, // fabric transmit data
  input wire logic [1:0] tx_force_neg_disp, // force negative disparity
  output logic [15:0] tx_data_out, // data to encoder
  output logic [1:0] tx_neg_disp, // force to encoder
  input wire logic dec_err, // 8b10b decode error
  input wire logic eb_ovf, // elastic buffer overflow
  input wire logic eb_unf, // elastic buffer underflow
  input wire logic disp_err, // disparity error
  input wire logic skp_add, // skp inserted
  input wire logic skp_del, // skp deleted
  input wire logic rxdet_done, // receiver detect finished
  input wire logic rxdet_found, // receiver present
  output logic [2:0] rx_status, // receiver status code
  output logic phy_done, // phy done pulse
  input wire logic eios_rx, // eios received
  input wire logic nfts_rx, // nfts received in l0
  input wire logic fc_or_skp_rx, // update fc or skp seen
  input wire logic ts_rx, // ts1 or ts2 seen
  input wire logic sig_det, // signal detect pin
  output logic lock_to_reference_mode, // cdr lock to reference
  output logic lock_to_data, // cdr lock to data
  output logic elec_idle // inferred electrical idle
);
  logic [2:0] sd_sync;
  logic sd;
  logic [31:0] ctrl;
  ppi_cdr_t cdr_state;
  ppi_cdr_t next_cdr_state;
  logic [15:0] fts_cnt;
  logic eios_seen;
  logic sd_q;
  logic [15:0] lock_cnt;
  ppi_idle_if ii ();

  // signal detect pin: three flops, change accepted when last two agree
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sd_sync <= 3'h0;
    else
      sd_sync <= {sd_sync[1:0], sig_det};
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sd <= 1'b0;
    else if (sd_sync[1] == sd_sync[2])
      sd <= sd_sync[2];
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != `PPI_ADDR_CTRL && paddr != `PPI_ADDR_STAT &&
    paddr != `PPI_ADDR_CNT;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ctrl <= 32'h0000_0000;
    else if (psel && penable && pwrite && paddr == `PPI_ADDR_CTRL)
      ctrl <= pwdata & 32'h0000_007F;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      case (paddr)
        `PPI_ADDR_CTRL: prdata <= ctrl;
        `PPI_ADDR_STAT: prdata <= {24'h000000, cdr_state, eios_seen, elec_idle, sd, rx_status};
        `PPI_ADDR_CNT: prdata <= {16'h0000, lock_cnt};
        default: prdata <= 32'h0000_0000;
      endcase
  end

  // transmit path: force flag travels with its word
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_data_out <= 16'h0000;
      tx_neg_disp <= 2'h0;
    end
    else
    begin
      tx_data_out <= tx_data_in;
      tx_neg_disp <= tx_force_neg_disp;
    end
  end

  // receiver status priority encoder
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_status <= `PPI_ST_OK;
      phy_done <= 1'b0;
    end
    else
    begin
      phy_done <= rxdet_done;
      if (rxdet_done)
        rx_status <= rxdet_found ? `PPI_ST_RX_DET : `PPI_ST_OK;
      else if (dec_err || (32'(eb_ovf) + 32'(eb_unf) + 32'(disp_err)) > 32'd1)
        rx_status <= `PPI_ST_DEC_ERR;
      else if (eb_ovf)
        rx_status <= `PPI_ST_OVF;
      else if (eb_unf)
        rx_status <= `PPI_ST_UNF;
      else if (disp_err)
        rx_status <= `PPI_ST_DISP;
      else if (skp_add)
        rx_status <= `PPI_ST_SKP_ADD;
      else if (skp_del)
        rx_status <= `PPI_ST_SKP_DEL;
      else
        rx_status <= `PPI_ST_OK;
    end
  end

  // fast recovery cdr control
  always_comb
  begin
    next_cdr_state = cdr_state;
    case (cdr_state)
      PPI_CDR_LTD:
        if (eios_rx || !sd)
          next_cdr_state = PPI_CDR_LTR;
      PPI_CDR_LTR:
        if (sd && nfts_rx)
          next_cdr_state = PPI_CDR_WAIT;
      PPI_CDR_WAIT:
        if (!sd)
          next_cdr_state = PPI_CDR_LTR;
        else if (fts_cnt >= 16'(FTS_MIN_CYC))
          next_cdr_state = PPI_CDR_LTD;
      default:
        next_cdr_state = PPI_CDR_LTR;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cdr_state <= PPI_CDR_LTR;
    else
      cdr_state <= next_cdr_state;
  end

  // dwell in reference lock before moving to data, capped by fts limit
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fts_cnt <= 16'h0000;
    else if (cdr_state != PPI_CDR_WAIT)
      fts_cnt <= 16'h0000;
    else if (fts_cnt < 16'(FTS_MAX_CYC))
      fts_cnt <= fts_cnt + 16'h0001;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      lock_cnt <= 16'h0000;
    else if (cdr_state == PPI_CDR_WAIT && next_cdr_state == PPI_CDR_LTD)
      lock_cnt <= lock_cnt + 16'h0001;
  end

  // eios memory for idle flag in 0xx mode, cleared when signal returns
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      eios_seen <= 1'b0;
      sd_q <= 1'b0;
    end
    else
    begin
      sd_q <= sd;
      if (eios_rx)
        eios_seen <= 1'b1;
      else if (sd && !sd_q)
        eios_seen <= 1'b0;
    end
  end

  // user lock bits only reach the cdr while fast recovery is off
  always_comb
  begin
    if (ctrl[`PPI_CTRL_FR])
    begin
      lock_to_reference_mode = (cdr_state != PPI_CDR_LTD);
      lock_to_data = (cdr_state == PPI_CDR_LTD);
    end
    else
    begin
      lock_to_reference_mode = ctrl[`PPI_CTRL_LTR];
      lock_to_data = ctrl[`PPI_CTRL_LTD];
    end
  end

  assign ii.enable = ctrl[`PPI_CTRL_EI];
  assign ii.sel = ctrl[`PPI_CTRL_SEL];
  assign ii.fc_or_skp = fc_or_skp_rx;
  assign ii.ts_seen = ts_rx;
  assign ii.idle_exit = sd && !sd_q;
  assign ii.eios_det = eios_seen;
  assign ii.sig_det = sd;

  ppi_idle_infer #(
    .WIN_CYC(WIN_CYC),
    .TS_CYC(TS_CYC),
    .EXIT_CYC(EXIT_CYC)
  ) u_infer (
    .ref_clk(ref_clk),
    .rst(rst),
    .ii(ii.inf)
  );

  assign elec_idle = ii.idle;
endmodule : ppi_top

/* hw/ppi_defines.svh */
// Purpose: constants for the pipe receive status and idle inference block
// Assumes: 100 MHz parallel clock
// Notes: times kept in their own units, cycle counts derived
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH
`define PPI_ST_OK 3'h0
`define PPI_ST_SKP_ADD 3'h1
`define PPI_ST_SKP_DEL 3'h2
`define PPI_ST_RX_DET 3'h3
`define PPI_ST_DEC_ERR 3'h4
`define PPI_ST_OVF 3'h5
`define PPI_ST_UNF 3'h6
`define PPI_ST_DISP 3'h7
`define PPI_CLK_MHZ 100
`define PPI_UI_PS 400
`define PPI_WIN_US 128
`define PPI_TS_UI 1280
`define PPI_EXIT_UI 2000
`define PPI_FTS_MIN_NS 16
`define PPI_FTS_MAX_NS 4000
`define PPI_WIN_CYC (`PPI_WIN_US * `PPI_CLK_MHZ)
`define PPI_TS_CYC ((`PPI_TS_UI * `PPI_UI_PS) / (1000000 / `PPI_CLK_MHZ))
`define PPI_EXIT_CYC ((`PPI_EXIT_UI * `PPI_UI_PS) / (1000000 / `PPI_CLK_MHZ))
`define PPI_FTS_MIN_CYC ((`PPI_FTS_MIN_NS * `PPI_CLK_MHZ + 999) / 1000)
`define PPI_FTS_MAX_CYC ((`PPI_FTS_MAX_NS * `PPI_CLK_MHZ) / 1000)
`define PPI_SEL_L0 3'h4
`define PPI_SEL_RCFG 3'h5
`define PPI_SEL_SPD_FAIL 3'h6
`define PPI_SEL_LPBK 3'h7
`define PPI_ADDR_CTRL 12'h000
`define PPI_ADDR_STAT 12'h004
`define PPI_ADDR_CNT 12'h008
`define PPI_CTRL_FR 0
`define PPI_CTRL_EI 1
`define PPI_CTRL_LTR 2
`define PPI_CTRL_LTD 3
`define PPI_CTRL_SEL 6:4
`endif

/* hw/ppi_pkg.sv */
// Purpose: types for the pipe receive status and idle inference block
// Assumes: constants live in ppi_defines.svh
// Notes: none
package ppi_pkg;
  typedef enum logic [1:0] {
    PPI_CDR_LTR = 2'b00,
    PPI_CDR_LTD = 2'b01,
    PPI_CDR_WAIT = 2'b10
  } ppi_cdr_t;
endpackage : ppi_pkg

/* hw/ppi_idle_if.sv */
// Purpose: carries idle inference inputs and result between modules
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface ppi_idle_if;
  logic enable;
  logic [2:0] sel;
  logic fc_or_skp;
  logic ts_seen;
  logic idle_exit;
  logic eios_det;
  logic sig_det;
  logic idle;
  modport ctl (output enable, output sel, output fc_or_skp, output ts_seen, output idle_exit,
    output eios_det, output sig_det, input idle);
  modport inf (input enable, input sel, input fc_or_skp, input ts_seen, input idle_exit,
    input eios_det, input sig_det, output idle);
endinterface : ppi_idle_if

/* hw/ppi_idle_infer.sv */
// Purpose: per-channel electrical idle inference
// Assumes: inputs are synchronous to ref_clk
// Notes: window counts restart whenever the awaited event arrives
`timescale 1ns/1ps
`include "ppi_defines.svh"
module ppi_idle_infer
  import ppi_pkg::*;
#(
  parameter int WIN_CYC = `PPI_WIN_CYC,
  parameter int TS_CYC = `PPI_TS_CYC,
  parameter int EXIT_CYC = `PPI_EXIT_CYC
)(
  input wire logic ref_clk, // parallel clock
  input wire logic rst, // async reset
  ppi_idle_if.inf ii // inference signals
);
  logic [15:0] cnt;
  logic [2:0] last_sel;
  logic evt;
  logic [15:0] lim;

  // the awaited event for each substate; eieos is never counted as an exit
  always_comb
  begin
    evt = 1'b0;
    lim = 16'(WIN_CYC);
    case (ii.sel)
      `PPI_SEL_L0:
      begin
        evt = ii.fc_or_skp;
        lim = 16'(WIN_CYC);
      end
      `PPI_SEL_RCFG:
      begin
        evt = ii.ts_seen;
        lim = 16'(TS_CYC);
      end
      `PPI_SEL_SPD_FAIL:
      begin
        evt = ii.idle_exit;
        lim = 16'(EXIT_CYC);
      end
      `PPI_SEL_LPBK:
      begin
        evt = ii.idle_exit;
        lim = 16'(WIN_CYC);
      end
      default:
      begin
        evt = 1'b0;
        lim = 16'(WIN_CYC);
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      last_sel <= 3'h0;
    else
      last_sel <= ii.sel;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cnt <= 16'h0000;
    else if (!ii.enable || evt || ii.sel != last_sel)
      cnt <= 16'h0000;
    else if (cnt != lim)
      cnt <= cnt + 16'h0001;
  end

  always_comb
  begin
    if (!ii.enable)
      ii.idle = ~ii.sig_det;
    else if (!ii.sel[2])
      ii.idle = ii.eios_det;
    else
      ii.idle = (cnt == lim);
  end
endmodule : ppi_idle_infer

/* tb/ppi_top_checker.sv */
// Purpose: port assertions for ppi_top
// Assumes: ctrl is mirrored from apb writes
// Notes: bound at the foot
`timescale 1ns/1ps
module ppi_top_checker
  import ppi_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic pready, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic dec_err, // status in
  input wire logic eb_ovf, // status in
  input wire logic eb_unf, // status in
  input wire logic disp_err, // status in
  input wire logic skp_add, // status in
  input wire logic skp_del, // status in
  input wire logic rxdet_done, // detect in
  input wire logic rxdet_found, // detect in
  input wire logic [2:0] rx_status, // status out
  input wire logic phy_done, // detect out
  input wire logic eios_rx, // eios in
  input wire logic fc_or_skp_rx, // fc in
  input wire logic sig_det, // pin
  input wire logic lock_to_reference_mode, // cdr
  input wire logic lock_to_data, // cdr
  input wire logic elec_idle // idle out
);
  logic [31:0] ctl;
  wire logic no_err = !(dec_err | eb_ovf | eb_unf | disp_err | rxdet_done);
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ctl <= 32'h0;
    else if (psel && penable && pwrite && pready && paddr == 12'h000)
      ctl <= pwdata;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_sd_low;
    (ctl[0] && !sig_det) [*8];
  endsequence
  sequence s_sd_steady;
    (!ctl[1] && $stable(sig_det)) [*8];
  endsequence
  a_decode_first: assert property (dec_err && !rxdet_done |=> rx_status == 3'h4)
    else $error("decode error not first");
  a_multi_error: assert property ($countones({eb_ovf, eb_unf, disp_err}) > 1 && !rxdet_done |=> rx_status == 3'h4)
    else $error("multiple errors not decode code");
  a_skp_code: assert property (no_err && skp_add |=> rx_status == 3'h1)
    else $error("skp added code wrong");
  a_quiet_ok: assert property (no_err && !skp_add && !skp_del |=> rx_status == 3'h0)
    else $error("quiet cycle not ok code");
  a_detect_done: assert property (rxdet_done |=> phy_done && rx_status == {1'b0, {2{$past(rxdet_found)}}})
    else $error("detect result wrong");
  a_done_pulse: assert property (!rxdet_done |=> !phy_done)
    else $error("done without detect");
  a_user_lock: assert property (!ctl[0] |-> lock_to_reference_mode == ctl[2] && lock_to_data == ctl[3])
    else $error("user lock controls not passed");
  a_fr_ref: assert property (s_sd_low |-> lock_to_reference_mode && !lock_to_data)
    else $error("no reference lock without signal");
  a_idle_off: assert property (s_sd_steady |-> elec_idle == !sig_det)
    else $error("idle not inverted detect");
  a_eios_idle: assert property (ctl[1] && !ctl[6] && eios_rx |=> elec_idle)
    else $error("eios did not set idle");
  a_event_clear: assert property (ctl[1] && ctl[6:4] == 3'h4 && fc_or_skp_rx |=> !elec_idle)
    else $error("fc or skp did not clear idle");
endmodule : ppi_top_checker
bind ppi_top ppi_top_checker i_chk (.ref_clk, .rst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .dec_err,
  .eb_ovf, .eb_unf, .disp_err, .skp_add, .skp_del, .rxdet_done, .rxdet_found, .rx_status, .phy_done, .eios_rx,
  .fc_or_skp_rx, .sig_det, .lock_to_reference_mode, .lock_to_data, .elec_idle);

/* tb/ppi_mac_model.sv */
// Purpose: fabric-side sender of the compliance pattern
// Assumes: 16-bit channel width, low byte first
// Notes: pattern restarts whenever en rises
`timescale 1ns/1ps
module ppi_mac_model (
  input wire logic ref_clk, // parallel clock
  input wire logic rst, // reset
  input wire logic en, // send pattern
  output logic [15:0] tx_data, // word to block
  output logic [1:0] force_nd // force negative disparity
);
  logic odd;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      odd <= 1'b0;
      tx_data <= 16'h0000;
      force_nd <= 2'b00;
    end
    else
    begin
      odd <= en && !odd;
      tx_data <= !en ? 16'h0000 : odd ? 16'h4ABC : 16'hB5BC;
      force_nd <= {1'b0, en && !odd};
    end
endmodule : ppi_mac_model

/* tb/tb_ppi_top.sv */
// Purpose: self-checking bench for ppi_top
// Assumes: shortened idle windows
// Notes: apb master waits for pready
`timescale 1ns/1ps
module tb_ppi_top;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] tx_data_in, tx_data_out, pd;
  logic [1:0] tx_force_neg_disp, tx_neg_disp, pf;
  logic [5:0] stv = 6'h00;
  logic rxdet_done = 1'b0, rxdet_found = 1'b0, eios_rx = 1'b0, nfts_rx = 1'b0, fc_or_skp_rx = 1'b0;
  logic ts_rx = 1'b0, sig_det = 1'b0, mac_en = 1'b0, phy_done, lock_to_reference_mode, lock_to_data, elec_idle;
  logic [2:0] rx_status;
  logic [8:0] tab [12] = '{9'h104, 9'h085, 9'h046, 9'h027, 9'h011, 9'h00A, 9'h184, 9'h0C4, 9'h037, 9'h019,
    9'h064, 9'h000};
  int failures = 0, compares = 0, k, lim;
  ppi_top #(.WIN_CYC(64), .TS_CYC(24), .EXIT_CYC(32)) i_ppi_top (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_data_in, .tx_force_neg_disp, .tx_data_out, .tx_neg_disp,
    .dec_err(stv[5]), .eb_ovf(stv[4]), .eb_unf(stv[3]), .disp_err(stv[2]), .skp_add(stv[1]), .skp_del(stv[0]),
    .rxdet_done, .rxdet_found, .rx_status, .phy_done, .eios_rx, .nfts_rx, .fc_or_skp_rx, .ts_rx, .sig_det,
    .lock_to_reference_mode, .lock_to_data, .elec_idle);
  ppi_mac_model i_ppi_mac_model (.ref_clk, .rst, .en(mac_en), .tx_data(tx_data_in), .force_nd(tx_force_neg_disp));
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    #100us;
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk({lock_to_reference_mode, elec_idle}, 2'b01);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'hC);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hC);
    chk({lock_to_reference_mode, lock_to_data}, 2'b11);
    apb(1'b0, 12'h00C, 32'h0);
    chk({perr, rd[30:0]}, 32'h80000000);
    mac_en <= 1'b1;
    #1;
    repeat (6)
    begin
      pd = tx_data_in;
      pf = tx_force_neg_disp;
      @(posedge ref_clk);
      #1;
      chk({tx_neg_disp, tx_data_out}, {pf, pd});
    end
    @(posedge ref_clk) mac_en <= 1'b0;
    for (k = 0; k < 14; k++)
    begin
      @(posedge ref_clk) {rxdet_done, rxdet_found, stv} <= k < 12 ? {2'b00, tab[k][8:3]} : {1'b1, k[0], 6'h20};
      @(posedge ref_clk) {rxdet_done, stv} <= 7'h00;
      #1;
      chk({phy_done, rx_status}, k < 12 ? {1'b0, tab[k][2:0]} : {2'b10, k[0], k[0]});
    end
    @(posedge ref_clk) sig_det <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(elec_idle, 1'b0);
    apb(1'b1, 12'h000, 32'h2);
    @(posedge ref_clk) eios_rx <= 1'b1;
    @(posedge ref_clk) eios_rx <= 1'b0;
    #1;
    chk(elec_idle, 1'b1);
    @(posedge ref_clk) sig_det <= 1'b0;
    repeat (8) @(posedge ref_clk);
    sig_det <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(elec_idle, 1'b0);
    for (k = 4; k < 8; k++)
    begin
      lim = (k == 5) ? 24 : (k == 6) ? 32 : 64;
      apb(1'b1, 12'h000, {25'h0, k[2:0], 4'h2});
      repeat (lim - 3) @(posedge ref_clk);
      #1;
      chk(elec_idle, 1'b0);
      repeat (6) @(posedge ref_clk);
      #1;
      chk(elec_idle, 1'b1);
      @(posedge ref_clk) {ts_rx, fc_or_skp_rx} <= {k == 5, k == 4};
      @(posedge ref_clk) {ts_rx, fc_or_skp_rx} <= 2'b00;
      #1;
      chk(elec_idle, k > 5);
    end
    apb(1'b1, 12'h000, 32'hD);
    #1;
    chk({lock_to_reference_mode, lock_to_data}, 2'b10);
    @(posedge ref_clk) nfts_rx <= 1'b1;
    @(posedge ref_clk) nfts_rx <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk({lock_to_reference_mode, lock_to_data}, 2'b01);
    @(posedge ref_clk) eios_rx <= 1'b1;
    @(posedge ref_clk) eios_rx <= 1'b0;
    #1;
    chk({lock_to_reference_mode, lock_to_data}, 2'b10);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h28);
    @(posedge ref_clk) sig_det <= 1'b0;
    repeat (10) @(posedge ref_clk);
    wrap_up();
  end
endmodule : tb_ppi_top
